// *** logic/lph_power_fsm.sv ***
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps

module lph_power_fsm #(
	parameter int MS_CYCLES = lph_pkg::MS_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        mediaEnergy,
	input  wire logic        linkUp,
	output lph_pkg::lph_pwr_t pwr
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		lph_pkg::lph_state_t            state;
		logic [lph_pkg::PRE_W-1:0]      pre;
		logic [lph_pkg::MS_W-1:0]       msCnt;
		logic [lph_pkg::MS_W-1:0]       sleepMs;
		logic [1:0]                     bursts;
		logic                           flpBurst;
		logic                           flpPairB;
		logic                           lowPower;
		logic                           wakeTx;
		lph_pkg::lph_ctrl_t             ctrl;
		logic                           aValid;
		logic                           aWrite;
		logic [lph_pkg::IDX_W-1:0]      aIdx;
		logic                           readyOut;
		logic                           respErr;
		logic [31:0]                    rdata;
	} lph_regs_t;

	lph_regs_t r_q;
	lph_regs_t r_d;

	logic       energySync;
	logic [7:0] rnd;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [lph_pkg::MS_W-1:0] pick4(
		input logic [1:0]                sel,
		input logic [lph_pkg::MS_W-1:0]  v0,
		input logic [lph_pkg::MS_W-1:0]  v1,
		input logic [lph_pkg::MS_W-1:0]  v2,
		input logic [lph_pkg::MS_W-1:0]  v3
	);
		logic [lph_pkg::MS_W-1:0] v;
		unique case (sel)
			2'h0: v = v0;
			2'h1: v = v1;
			2'h2: v = v2;
			2'h3: v = v3;
		endcase
		return v;
	endfunction

	// nominal minus 80 plus a draw in 0..140
	function automatic logic [lph_pkg::MS_W-1:0] sleepDraw(
		input logic [1:0] sel,
		input logic [7:0] draw
	);
		logic [7:0]               off;
		logic [lph_pkg::MS_W-1:0] nom;
		off = (draw >= lph_pkg::JITTER_SPAN_MS) ? 8'(draw - lph_pkg::JITTER_SPAN_MS) : draw;
		nom = pick4(sel, lph_pkg::SLEEP_MS_0, lph_pkg::SLEEP_MS_1,
			lph_pkg::SLEEP_MS_2, lph_pkg::SLEEP_MS_3);
		return lph_pkg::MS_W'(nom - lph_pkg::JITTER_NEG_MS + {5'h00, off});
	endfunction

	// word index of a byte address; byte lanes are not decoded
	function automatic logic [lph_pkg::IDX_W-1:0] regIdx(
		input logic [31:0] addr
	);
		return addr[lph_pkg::IDX_W+1:2];
	endfunction

	// a transfer is taken only while the bus is ready for an address phase
	function automatic logic busTake(
		input logic       sel,
		input logic [1:0] trans,
		input logic       rdy
	);
		return sel && trans[1] && rdy;
	endfunction

	function automatic logic [31:0] ctrlWord(
		input lph_pkg::lph_ctrl_t c
	);
		return {24'h000000, c};
	endfunction

	function automatic logic [31:0] statusWord(
		input lph_pkg::lph_state_t st,
		input logic [1:0]          n,
		input logic                link,
		input logic                energy
	);
		return {25'h0, n, link, energy, st};
	endfunction

	// compare after increment: the interval ends on the tick that reaches it
	function automatic logic timerDone(
		input logic [lph_pkg::MS_W-1:0] count,
		input logic [lph_pkg::MS_W-1:0] target
	);
		return count >= target;
	endfunction

	// ----------------------------------------------------------------
	// leaves
	// ----------------------------------------------------------------
	// energy synchroniser
	lph_sync2 u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.asyncIn (mediaEnergy),
		.syncOut (energySync)
	);

	lph_lfsr u_lfsr (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.rnd     (rnd)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic                     msTick;
		logic                     dataWr;
		lph_pkg::lph_ctrl_t       ctrlNow;
		logic [lph_pkg::MS_W-1:0] wakeMs;
		logic [lph_pkg::MS_W-1:0] linkMs;
		logic [lph_pkg::MS_W-1:0] msNext;
		logic                     goSleep;
		logic                     goWake;
		logic                     goNormal;

		r_d      = r_q;
		msTick   = (r_q.pre == lph_pkg::PRE_W'(MS_CYCLES - 1));
		dataWr   = r_q.aValid && r_q.aWrite && (r_q.aIdx == lph_pkg::IDX_CTRL);
		ctrlNow  = dataWr ? lph_pkg::lph_ctrl_t'(hwdata[7:0]) : r_q.ctrl;
		goSleep  = 1'b0;
		goWake   = 1'b0;
		goNormal = 1'b0;
		wakeMs   = '0;
		linkMs   = '0;
		msNext   = '0;
		r_d.flpBurst = 1'b0;

		// ------------------------------------------------------------
		// bus slave
		// ------------------------------------------------------------
		// zero wait, always OKAY
		r_d.readyOut = 1'b1;
		r_d.respErr  = 1'b0;
		if (dataWr) begin
			r_d.ctrl = ctrlNow;
		end
		r_d.aValid = busTake(hsel, htrans, hready);
		if (r_d.aValid) begin
			r_d.aWrite = hwrite;
			r_d.aIdx   = regIdx(haddr);
		end
		if (r_d.aValid && !hwrite) begin
			// status and control readable in every state
			unique case (regIdx(haddr))
				lph_pkg::IDX_CTRL: r_d.rdata = ctrlWord(ctrlNow);
				lph_pkg::IDX_STATUS: r_d.rdata = statusWord(r_q.state, r_q.bursts, linkUp, energySync);
				default: r_d.rdata = 32'h00000000;
			endcase
		end

		// ------------------------------------------------------------
		// time base
		// ------------------------------------------------------------
		// millisecond time base
		r_d.pre = msTick ? '0 : lph_pkg::PRE_W'(r_q.pre + 1'b1);
		msNext  = msTick ? lph_pkg::MS_W'(r_q.msCnt + 1'b1) : r_q.msCnt;
		r_d.msCnt = msNext;

		wakeMs = pick4(r_q.ctrl.wakeSel, lph_pkg::WAKE_MS_0, lph_pkg::WAKE_MS_1,
			lph_pkg::WAKE_MS_2, lph_pkg::WAKE_MS_3);
		linkMs = pick4(r_q.ctrl.linkSel, lph_pkg::LINK_MS_0, lph_pkg::LINK_MS_1,
			lph_pkg::LINK_MS_2, lph_pkg::LINK_MS_3);

		// ------------------------------------------------------------
		// power state machine
		// ------------------------------------------------------------
		unique case (r_q.state)
			lph_pkg::ST_SLEEP: begin
				if (energySync) begin
					goNormal = 1'b1;
				end else if (timerDone(msNext, r_q.sleepMs)) begin
					goWake = 1'b1;
				end
			end
			lph_pkg::ST_WAKE: begin
				if (energySync) begin
					goNormal = 1'b1;
				end else if (timerDone(msNext, wakeMs)) begin
					goSleep = 1'b1;
				end else if (msTick && r_q.msCnt[3:0] == lph_pkg::BURST_SLOT_LAST
					&& r_q.bursts != lph_pkg::BURST_MAX) begin
					// next burst on the other pair
					r_d.flpBurst = 1'b1;
					r_d.flpPairB = !r_q.flpPairB;
					r_d.bursts   = 2'(r_q.bursts + 1'b1);
				end
			end
			lph_pkg::ST_NORMAL: begin
				// only an autoneg port times out
				if (!r_q.ctrl.autoNeg || linkUp) begin
					r_d.msCnt = '0;
				end else if (timerDone(msNext, linkMs)) begin
					goSleep = 1'b1;
				end
			end
			default: begin
				goSleep = 1'b1;
			end
		endcase

		if (goSleep) begin
			r_d.state    = lph_pkg::ST_SLEEP;
			r_d.msCnt    = '0;
			r_d.sleepMs  = sleepDraw(r_q.ctrl.sleepSel, rnd);
		end else if (goWake) begin
			// first burst on pair A at entry
			r_d.state    = lph_pkg::ST_WAKE;
			r_d.msCnt    = '0;
			r_d.bursts   = 2'h1;
			r_d.flpBurst = 1'b1;
			r_d.flpPairB = 1'b0;
		end else if (goNormal) begin
			r_d.state    = lph_pkg::ST_NORMAL;
			r_d.msCnt    = '0;
		end

		// disabled port sits at full power
		if (!r_q.ctrl.enable) begin
			r_d.state    = lph_pkg::ST_NORMAL;
			r_d.msCnt    = '0;
			r_d.flpBurst = 1'b0;
		end
		if (r_d.state != lph_pkg::ST_WAKE) begin
			r_d.bursts = '0;
		end

		// ------------------------------------------------------------
		// power outputs
		// ------------------------------------------------------------
		// power down digital blocks in sleep only
		r_d.lowPower = (r_d.state == lph_pkg::ST_SLEEP);
		r_d.wakeTx   = (r_d.state == lph_pkg::ST_WAKE);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q.state    <= lph_pkg::ST_SLEEP;
			r_q.pre      <= '0;
			r_q.msCnt    <= '0;
			r_q.sleepMs  <= lph_pkg::SLEEP_MS_1;
			r_q.bursts   <= '0;
			r_q.flpBurst <= 1'b0;
			r_q.flpPairB <= 1'b0;
			r_q.lowPower <= 1'b1;
			r_q.wakeTx   <= 1'b0;
			r_q.ctrl     <= lph_pkg::CTRL_RESET;
			r_q.aValid   <= 1'b0;
			r_q.aWrite   <= 1'b0;
			r_q.aIdx     <= '0;
			r_q.readyOut <= 1'b1;
			r_q.respErr  <= 1'b0;
			r_q.rdata    <= 32'h00000000;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hrdata       = r_q.rdata;
	assign hreadyout    = r_q.readyOut;
	assign hresp        = r_q.respErr;
	assign pwr.lowPower = r_q.lowPower;
	assign pwr.wakeTx   = r_q.wakeTx;
	assign pwr.flpBurst = r_q.flpBurst;
	assign pwr.flpPairB = r_q.flpPairB;
	assign pwr.state    = r_q.state;

endmodule

// *** logic/lph_pkg.sv ***
package lph_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int PRE_W         = 18;
	localparam int MS_W          = 13;

	// sleep window around the nominal value, in ms
	localparam logic [MS_W-1:0] JITTER_NEG_MS  = 13'h0050;
	localparam logic [7:0]      JITTER_SPAN_MS = 8'h8D;

	// nominal sleep intervals, ms
	localparam logic [MS_W-1:0] SLEEP_MS_0 = 13'h03E8;
	localparam logic [MS_W-1:0] SLEEP_MS_1 = 13'h07D0;
	localparam logic [MS_W-1:0] SLEEP_MS_2 = 13'h0BB8;
	localparam logic [MS_W-1:0] SLEEP_MS_3 = 13'h0FA0;

	// wake-up intervals, ms
	localparam logic [MS_W-1:0] WAKE_MS_0 = 13'h0010;
	localparam logic [MS_W-1:0] WAKE_MS_1 = 13'h0020;
	localparam logic [MS_W-1:0] WAKE_MS_2 = 13'h0030;
	localparam logic [MS_W-1:0] WAKE_MS_3 = 13'h0040;

	// link status time-out, ms
	localparam logic [MS_W-1:0] LINK_MS_0 = 13'h01F4;
	localparam logic [MS_W-1:0] LINK_MS_1 = 13'h03E8;
	localparam logic [MS_W-1:0] LINK_MS_2 = 13'h07D0;
	localparam logic [MS_W-1:0] LINK_MS_3 = 13'h0FA0;

	// one burst slot per 16 ms, at most three bursts
	localparam logic [3:0] BURST_SLOT_LAST = 4'hF;
	localparam logic [1:0] BURST_MAX       = 2'h3;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int         IDX_W       = 6;
	localparam logic [5:0] IDX_CTRL    = 6'h00;
	localparam logic [5:0] IDX_STATUS  = 6'h01;
	localparam logic [7:0] CTRL_RESET  = 8'h06;

	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_ANEG_BIT   = 1;
	localparam int CTRL_SLEEP_LSB  = 2;
	localparam int CTRL_WAKE_LSB   = 4;
	localparam int CTRL_LINK_LSB   = 6;

	typedef struct packed {
		logic [1:0] linkSel;
		logic [1:0] wakeSel;
		logic [1:0] sleepSel;
		logic       autoNeg;
		logic       enable;
	} lph_ctrl_t;

	typedef enum logic [2:0] {
		ST_SLEEP  = 3'b001,
		ST_WAKE   = 3'b010,
		ST_NORMAL = 3'b100
	} lph_state_t;

	typedef struct packed {
		logic       lowPower;
		logic       wakeTx;
		logic       flpBurst;
		logic       flpPairB;
		lph_state_t state;
	} lph_pwr_t;

endpackage

// *** logic/lph_sync2.sv ***
`timescale 1ns/100ps

module lph_sync2 (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic asyncIn,
	output logic      syncOut
);

	logic meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q  <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule

// *** logic/lph_lfsr.sv ***
`timescale 1ns/100ps

module lph_lfsr (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	output logic      [7:0] rnd
);

	logic [15:0] lfsr_q;

	// free running so the sleep draw depends on when the machine asks
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_q <= 16'hACE1;
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		end
	end

	assign rnd = lfsr_q[7:0];

endmodule

// *** tb/lph_power_fsm_assertions.sv ***
`timescale 1ns/100ps

module lph_fsm_chk #(
	parameter int MS_CYCLES = 8
) (
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic              hreadyout,
	input wire logic              hresp,
	input wire logic              mediaEnergy,
	input wire lph_pkg::lph_pwr_t pwr
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// ----
	// sequences and properties
	// ----
	sequence s_energy;
		mediaEnergy [*3];
	endsequence
	sequence s_wake_entry;
		$rose(pwr.wakeTx);
	endsequence
	property p_lp_state;
		pwr.lowPower == (pwr.state == lph_pkg::ST_SLEEP);
	endproperty
	property p_wake_flag;
		pwr.wakeTx == (pwr.state == lph_pkg::ST_WAKE);
	endproperty
	property p_burst_wake;
		pwr.flpBurst |-> pwr.state == lph_pkg::ST_WAKE;
	endproperty
	property p_burst_pulse;
		pwr.flpBurst |=> !pwr.flpBurst;
	endproperty
	property p_first_burst;
		s_wake_entry |-> pwr.flpBurst && !pwr.flpPairB;
	endproperty
	property p_energy;
		s_energy |=> pwr.state == lph_pkg::ST_NORMAL;
	endproperty
	property p_wake_exit;
		$fell(pwr.wakeTx) |-> pwr.lowPower || pwr.state == lph_pkg::ST_NORMAL;
	endproperty
	property p_bus;
		hreadyout && !hresp;
	endproperty

	a_lp_state: assert property (p_lp_state) else $error("lowPower flag");
	a_wake_flag: assert property (p_wake_flag) else $error("wakeTx flag");
	a_burst_wake: assert property (p_burst_wake) else $error("burst off wake");
	a_burst_pulse: assert property (p_burst_pulse) else $error("burst width");
	a_first_burst: assert property (p_first_burst) else $error("first burst");
	a_energy: assert property (p_energy) else $error("energy ignored");
	a_wake_exit: assert property (p_wake_exit) else $error("wake exit");
	a_bus: assert property (p_bus) else $error("bus answer");
endmodule

bind lph_power_fsm lph_fsm_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
	.ref_clk    (ref_clk),
	.rst_n      (rst_n),
	.hreadyout  (hreadyout),
	.hresp      (hresp),
	.mediaEnergy(mediaEnergy),
	.pwr        (pwr)
);

// *** tb/lph_link_partner.sv ***
`timescale 1ns/100ps

module lph_link_partner (
	input wire logic       ref_clk,
	input wire logic       plugged,
	input wire logic [7:0] lag,
	output logic           mediaEnergy,
	output logic           linkUp
);
	// energy edges land mid-cycle: the pin has no relation to ref_clk
	initial begin
		mediaEnergy = 1'b0;
		forever begin
			@(posedge ref_clk);
			if (plugged !== mediaEnergy) begin
				repeat (lag) @(posedge ref_clk);
				#1.3;
				mediaEnergy = plugged;
			end
		end
	end

	initial linkUp = 1'b0;
	always @(posedge ref_clk) begin
		linkUp <= mediaEnergy;
	end
endmodule

// *** tb/lph_power_fsm_tb_top.sv ***
`timescale 1ns/100ps

module lph_power_fsm_tb_top;
	logic              ref_clk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic              mediaEnergy, linkUp, plugged;
	logic [31:0]       haddr, hwdata, hrdata, rd;
	logic [1:0]        htrans;
	logic [2:0]        hsize, pairs;
	logic [7:0]        lag;
	lph_pkg::lph_pwr_t pwr;
	int                err_total, cmp_count, n, bursts;

	lph_power_fsm #(.MS_CYCLES(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.mediaEnergy(mediaEnergy), .linkUp(linkUp), .pwr(pwr));
	lph_link_partner peer (.ref_clk(ref_clk), .plugged(plugged), .lag(lag),
		.mediaEnergy(mediaEnergy), .linkUp(linkUp));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(negedge ref_clk) begin
		if (pwr.flpBurst === 1'b1) begin
			bursts++;
			pairs = {pairs[1:0], pwr.flpPairB};
		end
	end

	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic inr(input int lo, input int hi);
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic waitst(input lph_pkg::lph_state_t s, input int lim);
		n = 0;
		while (pwr.state !== s && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
	endtask

	task automatic results;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#240000;
		err_total++;
		$display("[ERR] %0t watchdog", $time);
		results;
	end

	// ----
	// tests
	// ----
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		plugged = 1'b0;
		lag = 8'h03;
		bursts = 0;
		pairs = 3'h0;
		err_total = 0;
		cmp_count = 0;
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'({pwr.lowPower, pwr.state}), 32'h9);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(32'(pwr.state), 32'h4);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h6);
		bus(1'b0, 32'h8, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 32'h0, 32'h33);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h33);
		waitst(lph_pkg::ST_SLEEP, 5000);
		inr(3980, 4005);
		bursts = 0;
		waitst(lph_pkg::ST_WAKE, 9000);
		inr(7356, 8484);
		bus(1'b0, 32'h4, 32'h0);
		chk(rd & 32'h1F, 32'h2);
		waitst(lph_pkg::ST_SLEEP, 600);
		inr(500, 512);
		chk(32'(bursts), 32'h3);
		chk(32'(pairs), 32'h2);
		// autoneg dropped while sleeping: cycling must go on
		bus(1'b1, 32'h0, 32'h31);
		waitst(lph_pkg::ST_WAKE, 9000);
		inr(7000, 8484);
		waitst(lph_pkg::ST_SLEEP, 600);
		@(posedge ref_clk);
		plugged <= 1'b1;
		waitst(lph_pkg::ST_NORMAL, 20);
		inr(4, 9);
		@(posedge ref_clk);
		plugged <= 1'b0;
		repeat (4200) @(negedge ref_clk);
		chk(32'(pwr.state), 32'h4);
		bus(1'b1, 32'h0, 32'h33);
		waitst(lph_pkg::ST_SLEEP, 4100);
		inr(3980, 4005);
		bus(1'b1, 32'h0, 32'h32);
		repeat (2) @(negedge ref_clk);
		chk(32'(pwr.state), 32'h4);
		bus(1'b1, 32'h0, 32'h33);
		bus(1'b1, 32'h0, 32'h31);
		repeat (4200) @(negedge ref_clk);
		chk(32'(pwr.state), 32'h4);
		results;
	end
endmodule
